// File: bench/sbs_host.sv
// Host loader model: 8N1 sender and background receiver
`timescale 1ns/1ps
module sbs_host #(
    parameter BIT_CYC = 16
) (
    input  wire       clk,
    input  wire       tx,
    input  wire       oe_n,
    output reg        rx
);
    // Pull-up holds the line high while the device releases it
    wire        line = oe_n ? 1'b1 : tx;
    logic [7:0] b;
    logic [7:0] q[$];
    int         n_bad;
    initial begin
        rx = 1'b1;
        n_bad = 0;
    end
    task automatic send_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 rx = f[i];
            repeat (BIT_CYC - 1) @(posedge clk);
        end
    endtask
    always begin
        @(negedge line);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = line;
        end
        repeat (BIT_CYC) @(posedge clk);
        if (line) q.push_back(b);
        else n_bad++;
    end
endmodule // sbs_host

// File: bench/sbs_properties.sv
// Port properties of the serial boot supervisor
`timescale 1ns/1ps
module sbs_properties #(
    parameter WATCH_CYC = 2000,
    parameter BIT_CYC   = 16
) (
    input wire        clk,
    input wire        rst_n,
    input wire        loader_receive_pin,
    input wire        loader_transmit_pin,
    input wire        loader_transmit_oe_n,
    input wire        serial_pins_released,
    input wire        user_run,
    input wire        session_active,
    input wire        code_protect,
    input wire [10:0] user_fetch_addr,
    input wire [13:0] user_fetch_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    int cnt;
    // Edges since reset, saturating past the window
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt <= 0;
        else if (cnt < WATCH_CYC + 8) cnt <= cnt + 1;
    end
    AST_NO_PROTECT: assert property (!code_protect)
        else $error("code protection enabled");
    AST_RUN_TIME: assert property ($rose(user_run) |->
        cnt >= WATCH_CYC - 1 && cnt <= WATCH_CYC + 2)
        else $error("user program started at wrong time");
    AST_DECIDED: assert property (cnt == WATCH_CYC + 3 |->
        user_run || session_active)
        else $error("no decision after window");
    AST_EXCLUSIVE: assert property (session_active |-> !user_run)
        else $error("user program runs during session");
    AST_ACT: assert property ($fell(loader_receive_pin) &&
        cnt < WATCH_CYC - 2 |-> ##[1:4] session_active)
        else $error("activity did not enter session");
    AST_STICKY: assert property (user_run |=> user_run)
        else $error("user program stopped");
    AST_RELEASE: assert property (user_run |->
        serial_pins_released && loader_transmit_oe_n)
        else $error("serial pins held while user runs");
    AST_OE: assert property (!loader_transmit_oe_n |->
        session_active)
        else $error("transmit driven outside session");
    AST_IDLE: assert property (!session_active |->
        loader_transmit_pin)
        else $error("transmit line not idle high");
    AST_BIT: assert property ($fell(loader_transmit_pin) |->
        (!loader_transmit_pin) [*8])
        else $error("transmit bit too short");
    CV_RUN: cover property ($rose(user_run));
    CV_SES: cover property ($rose(session_active));
    CV_TX: cover property ($fell(loader_transmit_oe_n));
endmodule // sbs_properties

// File: bench/tb.sv
// Self-checking bench for the serial boot supervisor
`timescale 1ns/1ps
module tb;
    localparam W = 2000;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [10:0] user_fetch_addr = 11'h000;
    wire         rx, tx, oe_n, rel, run, ses, cp;
    wire  [13:0] word;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [13:0] w;
    always #25 clk = ~clk;
    sbs_serial_boot_supervisor #(.WATCH_CYC(W), .BIT_CYC(16)) i_dut (
        .clk(clk), .rst_n(rst_n), .loader_receive_pin(rx),
        .loader_transmit_pin(tx), .loader_transmit_oe_n(oe_n),
        .serial_pins_released(rel), .user_run(run),
        .session_active(ses), .code_protect(cp),
        .user_fetch_addr(user_fetch_addr), .user_fetch_word(word));
    sbs_host #(.BIT_CYC(16)) i_host (
        .clk(clk), .tx(tx), .oe_n(oe_n), .rx(rx));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic get(output logic [7:0] d);
        int k;
        k = 0;
        while (i_host.q.size() == 0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        d = (i_host.q.size() != 0) ? i_host.q.pop_front() : 8'hxx;
    endtask
    task automatic reset_dut;
        @(posedge clk);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [10:0] a);
        i_host.send_byte(c);
        i_host.send_byte({5'h00, a[10:8]});
        i_host.send_byte(a[7:0]);
    endtask
    task automatic wr(input logic [7:0] c, input logic [10:0] a,
                      input logic [13:0] d);
        cmd(c, a);
        if (c == 8'h02) i_host.send_byte({2'b00, d[13:8]});
        i_host.send_byte(d[7:0]);
    endtask
    task automatic rd(input logic [7:0] c, input logic [10:0] a,
                      output logic [13:0] v);
        logic [7:0] hi, lo;
        hi = 8'h00;
        cmd(c, a);
        if (c == 8'h01) get(hi);
        get(lo);
        v = {hi[5:0], lo};
    endtask
    task automatic fetch(input logic [10:0] a, input logic [13:0] exp);
        @(posedge clk);
        #1 user_fetch_addr = a;
        @(posedge clk);
        @(negedge clk);
        chk(word, exp);
    endtask
    task automatic t_expire;
        int k;
        k = 0;
        reset_dut();
        while (run !== 1'b1 && k < 3 * W) begin
            @(negedge clk);
            k++;
        end
        chk(k >= W - 1 && k <= W + 2, 14'h0001);
        chk({ses, rel, oe_n, cp}, 14'h0006);
    endtask
    task automatic t_session;
        reset_dut();
        repeat (100) @(posedge clk);
        wr(8'h02, 11'h005, 14'h1a5c);
        chk({ses, run}, 14'h0002);
        wr(8'h02, 11'h000, 14'h0abc);
        wr(8'h04, 11'h010, 14'h005a);
        wr(8'h02, 11'h001, 14'h0123);
        wr(8'h02, 11'h7fd, 14'h3fff);
        i_host.send_byte(8'h7e);
        rd(8'h01, 11'h005, w);
        chk(w, 14'h1a5c);
        rd(8'h01, 11'h000, w);
        chk(w, 14'h0abc);
        rd(8'h01, 11'h001, w);
        chk(w, 14'h0123);
        rd(8'h03, 11'h010, w);
        chk(w, 14'h005a);
        repeat (2 * W) @(posedge clk);
        chk({ses, run}, 14'h0002);
        chk(14'(i_host.q.size() + i_host.n_bad), 14'h0000);
    endtask
    task automatic t_reloc;
        reset_dut();
        repeat (W + 10) @(posedge clk);
        chk(run, 14'h0001);
        fetch(11'h000, 14'h2f00);
        fetch(11'h005, 14'h1a5c);
        fetch(11'h001, 14'h2f00);
        fetch(11'h7fc, 14'h0abc);
        fetch(11'h7fd, 14'h0123);
    endtask
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        t_expire();
        t_session();
        t_reloc();
        end_of_test();
    end
endmodule // tb
bind sbs_serial_boot_supervisor sbs_properties #(
    .WATCH_CYC(WATCH_CYC), .BIT_CYC(BIT_CYC)) i_props (
    .clk(clk), .rst_n(rst_n), .loader_receive_pin(loader_receive_pin),
    .loader_transmit_pin(loader_transmit_pin),
    .loader_transmit_oe_n(loader_transmit_oe_n),
    .serial_pins_released(serial_pins_released), .user_run(user_run),
    .session_active(session_active), .code_protect(code_protect),
    .user_fetch_addr(user_fetch_addr), .user_fetch_word(user_fetch_word));

// File: rtl/sbs_consts.vh
// Constants for the serial boot supervisor
`ifndef SBS_CONSTS_VH
`define SBS_CONSTS_VH
`define SBS_CLK_HZ          20000000
`define SBS_WATCH_MS        200
`define SBS_WATCH_CYC       ((`SBS_CLK_HZ / 1000) * `SBS_WATCH_MS)
`define SBS_BAUD            19200
`define SBS_BIT_CYC         ((`SBS_CLK_HZ + `SBS_BAUD - 1) / `SBS_BAUD)
`define SBS_CODE_WORDS      2048
`define SBS_CODE_AW         11
`define SBS_LOADER_WORDS    256
`define SBS_LOADER_BASE     11'h700
`define SBS_RELOC_BASE      11'h7fc
`define SBS_VEC_WORDS       4
`define SBS_JUMP_WORD       14'h2f00
`define SBS_DATA_WORDS      256
`define SBS_CMD_RD_CODE     8'h01
`define SBS_CMD_WR_CODE     8'h02
`define SBS_CMD_RD_DATA     8'h03
`define SBS_CMD_WR_DATA     8'h04
`endif

// File: rtl/sbs_serial_boot_supervisor.v
// Serial boot supervisor: watch window, download session, hand-off
// Summary of operation
// (RULE1) Watch receive pin 200 ms after reset
// (RULE2) Activity enters session, else run user
// (RULE3) User starts only after full window
// (RULE4) Loader owns top 256 code words
// (RULE5) Relocate vector words, store loader jump
// (RULE6) Host access to 0..3 uses relocated copy
// (RULE7) Only code and data space reachable
// (RULE8) Fixed 19200 baud serial link
// (RULE9) Release serial pins when user runs
// (RULE10) No loader resources used while user runs
// (RULE11) Code protection never enabled
// (RULE12) User never jumps into addresses 0..3
// (RULE13) 8N1 frames, LSB first, idle high
`timescale 1ns/1ps
`include "sbs_consts.vh"
module sbs_serial_boot_supervisor #(
    parameter WATCH_CYC = `SBS_WATCH_CYC,
    parameter BIT_CYC   = `SBS_BIT_CYC
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        loader_receive_pin,
    output reg         loader_transmit_pin,
    output reg         loader_transmit_oe_n,
    output reg         serial_pins_released,
    output reg         user_run,
    output reg         session_active,
    output wire        code_protect,
    input  wire [10:0] user_fetch_addr,
    output reg  [13:0] user_fetch_word
);
    localparam [3:0] ST_WATCH = 4'h1;
    localparam [3:0] ST_SESS  = 4'h2;
    localparam [3:0] ST_USER  = 4'h4;
    localparam [3:0] ST_IDLE  = 4'h8;
    // Counter end and reload values, cut to the counter widths where used
    localparam integer WATCH_LAST = WATCH_CYC - 1;
    localparam integer BIT_HALF   = BIT_CYC / 2;
    localparam integer BIT_LAST   = BIT_CYC - 1;

    reg [13:0] code_mem [0:`SBS_CODE_WORDS-1];
    reg [7:0]  data_mem [0:`SBS_DATA_WORDS-1];
    reg [3:0]  state;
    reg [22:0] watch_cnt;
    reg        rx_prev;

    // Receiver
    reg [15:0] rx_cnt;
    reg [3:0]  rx_bit;
    reg [7:0]  rx_shift;
    reg        rx_busy;
    reg        rx_valid;
    reg [7:0]  rx_byte;

    // Two-entry transmit buffer
    reg [7:0]  buf_data [0:1];
    reg        buf_wp;
    reg        buf_rp;
    reg [1:0]  buf_cnt;
    wire       buf_in_ready = (buf_cnt != 2'h2);
    wire       buf_out_valid = (buf_cnt != 2'h0);
    reg        tx_load;
    reg        buf_in_valid;
    reg [7:0]  buf_in_data;

    // Transmitter
    reg [15:0] tx_cnt;
    reg [3:0]  tx_bit;
    reg [9:0]  tx_shift;
    reg        tx_busy;
    wire       tx_ready = ~tx_busy;

    // Command parser
    reg [2:0]  cmd_phase;
    reg [7:0]  cmd;
    reg [10:0] cmd_addr;
    reg [5:0]  cmd_hi;
    reg [1:0]  rsp_left;
    reg [13:0] rsp_word;

    assign code_protect = 1'b0; // RULE11

    // Host view of code space: vector words come from the relocated copy
    function [10:0] host_map;
        input [10:0] a;
        begin
            if (a < `SBS_VEC_WORDS) // RULE6
                host_map = `SBS_RELOC_BASE + a;
            else
                host_map = a;
        end
    endfunction

    function in_loader;
        input [10:0] a;
        begin
            in_loader = (a >= `SBS_LOADER_BASE); // RULE4
        end
    endfunction

    always @(posedge clk) begin
        user_fetch_word <= code_mem[user_fetch_addr];
    end

    // Supervisor state machine
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_WATCH;
            watch_cnt <= 23'h0;
            rx_prev <= 1'b1;
            user_run <= 1'b0;
            session_active <= 1'b0;
            serial_pins_released <= 1'b0;
        end else begin
            rx_prev <= loader_receive_pin;
            case (state)
                ST_WATCH: begin
                    if (rx_prev && !loader_receive_pin) begin // RULE1
                        state <= ST_SESS; // RULE2
                        session_active <= 1'b1;
                    end else if (watch_cnt == WATCH_LAST[22:0]) begin // RULE3
                        state <= ST_USER;
                        user_run <= 1'b1;
                        serial_pins_released <= 1'b1; // RULE9
                    end else begin
                        watch_cnt <= watch_cnt + 23'h1;
                    end
                end
                ST_SESS: state <= ST_SESS;
                ST_USER: state <= ST_USER; // RULE10
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Receiver, 8N1 at fixed rate, sampled mid-bit
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_cnt <= 16'h0;
            rx_bit <= 4'h0;
            rx_shift <= 8'h00;
            rx_busy <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (state != ST_SESS) begin // RULE10
                rx_busy <= 1'b0;
            end else if (!rx_busy) begin
                if (!loader_receive_pin) begin // RULE13
                    rx_busy <= 1'b1;
                    rx_cnt <= BIT_HALF[15:0];
                    rx_bit <= 4'h0;
                end
            end else if (rx_cnt != 16'h0) begin
                rx_cnt <= rx_cnt - 16'h1;
            end else begin
                rx_cnt <= BIT_LAST[15:0]; // RULE8
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && loader_receive_pin)
                    rx_busy <= 1'b0;
                else if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
                    rx_shift <= {loader_receive_pin, rx_shift[7:1]};
                else if (rx_bit == 4'h9) begin
                    rx_busy <= 1'b0;
                    if (loader_receive_pin) begin
                        rx_valid <= 1'b1;
                        rx_byte <= rx_shift;
                    end
                end
            end
        end
    end

    // Command parser: cmd, addr hi, addr lo, then data hi/lo on code writes, data lo only on data writes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_phase <= 3'h0;
            cmd <= 8'h00;
            cmd_addr <= 11'h000;
            cmd_hi <= 6'h00;
            rsp_left <= 2'h0;
            rsp_word <= 14'h0000;
        end else begin
            if (rsp_left != 2'h0 && buf_in_ready)
                rsp_left <= rsp_left - 2'h1;
            if (rx_valid && rsp_left == 2'h0) begin
                case (cmd_phase)
                    3'h0: begin
                        cmd <= rx_byte;
                        if (rx_byte == `SBS_CMD_RD_CODE ||
                            rx_byte == `SBS_CMD_WR_CODE ||
                            rx_byte == `SBS_CMD_RD_DATA ||
                            rx_byte == `SBS_CMD_WR_DATA) // RULE7
                            cmd_phase <= 3'h1;
                    end
                    3'h1: begin
                        cmd_addr[10:8] <= rx_byte[2:0];
                        cmd_phase <= 3'h2;
                    end
                    3'h2: begin
                        cmd_addr[7:0] <= rx_byte;
                        if (cmd == `SBS_CMD_RD_CODE) begin
                            rsp_word <= code_mem[host_map(
                                {cmd_addr[10:8], rx_byte})];
                            rsp_left <= 2'h2;
                            cmd_phase <= 3'h0;
                        end else if (cmd == `SBS_CMD_RD_DATA) begin
                            rsp_word <= {6'h00, data_mem[rx_byte]};
                            rsp_left <= 2'h1;
                            cmd_phase <= 3'h0;
                        end else if (cmd == `SBS_CMD_WR_DATA)
                            cmd_phase <= 3'h4;
                        else
                            cmd_phase <= 3'h3;
                    end
                    3'h3: begin
                        cmd_hi <= rx_byte[5:0];
                        cmd_phase <= 3'h4;
                    end
                    default: begin
                        cmd_phase <= 3'h0;
                    end
                endcase
            end
        end
    end

    // Memory writes; the loader region takes only the relocated vector words at 11'h7fc..11'h7ff
    always @(posedge clk) begin
        if (rx_valid && rsp_left == 2'h0 && cmd_phase == 3'h4) begin
            if (cmd == `SBS_CMD_WR_DATA)
                data_mem[cmd_addr[7:0]] <= rx_byte;
            else if (cmd_addr < `SBS_VEC_WORDS) begin
                code_mem[host_map(cmd_addr)] <= {cmd_hi, rx_byte}; // RULE5
                code_mem[cmd_addr] <= `SBS_JUMP_WORD; // RULE5
            end else if (!in_loader(cmd_addr))
                code_mem[cmd_addr] <= {cmd_hi, rx_byte}; // RULE4
        end
    end

    // Response bytes, high then low for code reads, low only for data reads, into the buffer
    always @* begin
        buf_in_valid = (rsp_left != 2'h0);
        buf_in_data = (rsp_left == 2'h2) ? {2'b00, rsp_word[13:8]}
                                         : rsp_word[7:0];
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            buf_data[0] <= 8'h00;
            buf_data[1] <= 8'h00;
        end else begin
            if (buf_in_valid && buf_in_ready) begin
                buf_data[buf_wp] <= buf_in_data;
                buf_wp <= ~buf_wp;
            end
            if (tx_load)
                buf_rp <= ~buf_rp;
            buf_cnt <= buf_cnt + {1'b0, buf_in_valid & buf_in_ready}
                       - {1'b0, tx_load};
        end
    end

    always @* begin
        tx_load = buf_out_valid && tx_ready;
    end

    // Transmitter, driven only during a session
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_cnt <= 16'h0;
            tx_bit <= 4'h0;
            tx_shift <= 10'h3ff;
            tx_busy <= 1'b0;
            loader_transmit_pin <= 1'b1;
            loader_transmit_oe_n <= 1'b1;
        end else begin
            loader_transmit_oe_n <= (state != ST_SESS); // RULE9
            if (tx_load) begin
                tx_shift <= {1'b1, buf_data[buf_rp], 1'b0}; // RULE13
                tx_busy <= 1'b1;
                tx_cnt <= BIT_LAST[15:0];
                tx_bit <= 4'h0;
                loader_transmit_pin <= 1'b0;
            end else if (tx_busy) begin
                if (tx_cnt != 16'h0)
                    tx_cnt <= tx_cnt - 16'h1;
                else begin
                    tx_cnt <= BIT_LAST[15:0]; // RULE8
                    tx_bit <= tx_bit + 4'h1;
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    loader_transmit_pin <= tx_shift[1];
                    if (tx_bit == 4'h9) begin
                        tx_busy <= 1'b0;
                        loader_transmit_pin <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // sbs_serial_boot_supervisor
